// ===== logic/motion_limit_object_bank.sv
// object bank holding motion limits and profile settings, with limited setpoint outputs
`timescale 1ns/1ps
module motion_limit_object_bank #(
	parameter int NODE_ID_W = 8
) (
	input  wire logic                           ref_clk_in,
	input  wire logic                           resetn_in,
	input  wire motion_limit_pkg::obj_req_t     req_in,
	output logic [31:0]                         rd_data_out,
	output logic                                ack_out,
	output logic                                abort_out,
	input  wire logic signed [31:0]             target_pos_in,
	input  wire logic                           target_valid_in,
	input  wire logic [7:0]                     mode_in,
	input  wire logic [NODE_ID_W-1:0]           node_id_in,
	input  wire logic                           revert_in,
	output logic [NODE_ID_W-1:0]                node_id_out,
	output motion_limit_pkg::motion_set_t       demand_out
);
	import motion_limit_pkg::*;

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	// the node id floor must be representable
	generate
		if (NODE_ID_W < 4 || NODE_ID_W > 8) begin : g_bad_w
			$error("node id width must be 4 to 8");
		end
	endgenerate

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// symmetric clamp of a signed speed to an unsigned magnitude
	function automatic logic signed [31:0] clamp_speed(input logic signed [31:0] v, input logic [31:0] lim);
		logic signed [32:0] v33;
		logic signed [32:0] l33;
		v33 = {v[31], v};
		l33 = {1'b0, lim};
		if (v33 > l33)
			clamp_speed = lim;
		else if (v33 < -l33)
			clamp_speed = 32'(-l33);
		else
			clamp_speed = v;
	endfunction

	// object address match
	function automatic logic hit(input obj_req_t r, input logic [15:0] idx, input logic [7:0] sub);
		hit = (r.index == idx) && (r.sub == sub);
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic signed [31:0]   min_position_limit_reg, min_position_limit_next;
	logic signed [31:0]   max_position_limit_reg, max_position_limit_next;
	logic [31:0]          max_shaft_speed_reg, max_shaft_speed_next;
	logic [31:0]          profile_cruise_velocity_reg, profile_cruise_velocity_next;
	logic [31:0]          profile_accel_rate_reg, profile_accel_rate_next;
	logic [31:0]          profile_decel_rate_reg, profile_decel_rate_next;
	logic signed [31:0]   velocity_setpoint_reg, velocity_setpoint_next;
	logic [31:0]          rd_data_reg, rd_data_next;
	logic                 ack_reg, ack_next;
	logic                 abort_reg, abort_next;
	logic [NODE_ID_W-1:0] node_id_reg, node_id_next;
	motion_set_t          demand_reg, demand_next;
	logic [31:0]          cruise_eff;
	logic                 ramp_mode;
	logic                 vel_mode;

	// ----------------------------------------
	// object access and limiting
	// ----------------------------------------
	// writes land one cycle after the request; reads answer in the same cycle as the ack
	always_comb begin
		min_position_limit_next      = min_position_limit_reg;
		max_position_limit_next      = max_position_limit_reg;
		max_shaft_speed_next         = max_shaft_speed_reg;
		profile_cruise_velocity_next = profile_cruise_velocity_reg;
		profile_accel_rate_next      = profile_accel_rate_reg;
		profile_decel_rate_next      = profile_decel_rate_reg;
		velocity_setpoint_next       = velocity_setpoint_reg;
		rd_data_next                 = rd_data_reg;
		ack_next                     = 1'b0;
		abort_next                   = 1'b0;
		node_id_next                 = node_id_reg;
		demand_next                  = demand_reg;

		if (req_in.wr) begin
			ack_next = 1'b1;
			if (hit(req_in, IDX_POS_LIMIT, SUB_MIN_POS))
				min_position_limit_next = req_in.data;
			else if (hit(req_in, IDX_POS_LIMIT, SUB_MAX_POS))
				max_position_limit_next = req_in.data;
			else if (hit(req_in, IDX_MAX_SPEED, SUB_ZERO))
				max_shaft_speed_next = req_in.data;
			else if (hit(req_in, IDX_PROFILE_VEL, SUB_ZERO))
				profile_cruise_velocity_next = req_in.data;
			else if (hit(req_in, IDX_ACCEL, SUB_ZERO))
				profile_accel_rate_next = req_in.data;
			else if (hit(req_in, IDX_DECEL, SUB_ZERO))
				profile_decel_rate_next = req_in.data;
			else if (hit(req_in, IDX_VEL_SETPT, SUB_ZERO))
				velocity_setpoint_next = req_in.data;
			else begin
				// the capability mask is read-only, so a write to it aborts too
				ack_next   = 1'b0;
				abort_next = 1'b1;
			end
		end else if (req_in.rd) begin
			ack_next = 1'b1;
			if (hit(req_in, IDX_POS_LIMIT, SUB_MIN_POS))
				rd_data_next = min_position_limit_reg;
			else if (hit(req_in, IDX_POS_LIMIT, SUB_MAX_POS))
				rd_data_next = max_position_limit_reg;
			else if (hit(req_in, IDX_MAX_SPEED, SUB_ZERO))
				rd_data_next = max_shaft_speed_reg;
			else if (hit(req_in, IDX_PROFILE_VEL, SUB_ZERO))
				rd_data_next = profile_cruise_velocity_reg;
			else if (hit(req_in, IDX_ACCEL, SUB_ZERO))
				rd_data_next = profile_accel_rate_reg;
			else if (hit(req_in, IDX_DECEL, SUB_ZERO))
				rd_data_next = profile_decel_rate_reg;
			else if (hit(req_in, IDX_VEL_SETPT, SUB_ZERO))
				rd_data_next = velocity_setpoint_reg;
			else if (hit(req_in, IDX_DRIVE_MODES, SUB_ZERO))
				rd_data_next = DRIVE_MODES_VAL;
			else begin
				ack_next     = 1'b0;
				abort_next   = 1'b1;
				rd_data_next = RST_ZERO;
			end
		end

		// clip only on a new target; between targets the last demand holds
		if (target_valid_in) begin
			if (target_pos_in < min_position_limit_reg)
				demand_next.pos = min_position_limit_reg;
			else if (target_pos_in > max_position_limit_reg)
				demand_next.pos = max_position_limit_reg;
			else
				demand_next.pos = target_pos_in;
		end

		// velocity demand follows the current mode every cycle
		if (vel_mode)
			demand_next.vel = clamp_speed(velocity_setpoint_reg, max_shaft_speed_reg);
		else if (mode_in == MODE_PP)
			demand_next.vel = clamp_speed(cruise_eff, max_shaft_speed_reg);
		else
			demand_next.vel = RST_ZERO;
		demand_next.cruise = cruise_eff;
		demand_next.accel  = ramp_mode ? profile_accel_rate_reg : RST_ZERO;
		demand_next.decel  = ramp_mode ? profile_decel_rate_reg : RST_ZERO;

		// ids below the floor are invalid after returning to the native protocol
		if (revert_in)
			node_id_next = (node_id_in < NODE_ID_W'(NODE_ID_FLOOR)) ? NODE_ID_W'(NODE_ID_FLOOR) : node_id_in;
	end

	// cruise speed capped at the shaft limit
	assign cruise_eff = (profile_cruise_velocity_reg > max_shaft_speed_reg) ?
		max_shaft_speed_reg : profile_cruise_velocity_reg;
	assign ramp_mode  = (mode_in == MODE_PP) || (mode_in == MODE_PV);
	assign vel_mode   = (mode_in == MODE_PV) || (mode_in == MODE_CSV);

	// registers only
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			min_position_limit_reg      <= RST_ZERO;
			max_position_limit_reg      <= RST_ZERO;
			max_shaft_speed_reg         <= RST_MAX_SPEED;
			profile_cruise_velocity_reg <= RST_ZERO;
			profile_accel_rate_reg      <= RST_ZERO;
			profile_decel_rate_reg      <= RST_ZERO;
			velocity_setpoint_reg       <= RST_ZERO;
			rd_data_reg                 <= RST_ZERO;
			ack_reg                     <= 1'b0;
			abort_reg                   <= 1'b0;
			node_id_reg                 <= NODE_ID_W'(NODE_ID_FLOOR);
			demand_reg                  <= '0;
		end else begin
			min_position_limit_reg      <= min_position_limit_next;
			max_position_limit_reg      <= max_position_limit_next;
			max_shaft_speed_reg         <= max_shaft_speed_next;
			profile_cruise_velocity_reg <= profile_cruise_velocity_next;
			profile_accel_rate_reg      <= profile_accel_rate_next;
			profile_decel_rate_reg      <= profile_decel_rate_next;
			velocity_setpoint_reg       <= velocity_setpoint_next;
			rd_data_reg                 <= rd_data_next;
			ack_reg                     <= ack_next;
			abort_reg                   <= abort_next;
			node_id_reg                 <= node_id_next;
			demand_reg                  <= demand_next;
		end
	end

	// outputs straight from flops
	assign rd_data_out = rd_data_reg;
	assign ack_out     = ack_reg;
	assign abort_out   = abort_reg;
	assign node_id_out = node_id_reg;
	assign demand_out  = demand_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// one clock domain, so clock and reset are given once for every property
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	// ----------------------------------------
	// position clipping checks
	// ----------------------------------------

	clip_low_a: assert property (target_valid_in && target_pos_in < min_position_limit_reg |=>
		demand_out.pos == $past(min_position_limit_reg)) else $error("target below min not clipped");
	clip_high_a: assert property (target_valid_in && target_pos_in > max_position_limit_reg
		&& target_pos_in >= min_position_limit_reg |=> demand_out.pos == $past(max_position_limit_reg))
		else $error("target above max not clipped");
	csp_within_a: assert property (target_valid_in && mode_in == MODE_CSP
		&& target_pos_in >= min_position_limit_reg && target_pos_in <= max_position_limit_reg
		|=> demand_out.pos == $past(target_pos_in))
		else $error("in-range target altered");
	pos_hold_a: assert property (!target_valid_in |=> demand_out.pos == $past(demand_out.pos))
		else $error("position demand moved without a target");
	min_write_a: assert property (req_in.wr && hit(req_in, IDX_POS_LIMIT, SUB_MIN_POS)
		|=> min_position_limit_reg == $past(req_in.data)) else $error("min limit write lost");
	max_write_a: assert property (req_in.wr && hit(req_in, IDX_POS_LIMIT, SUB_MAX_POS)
		|=> max_position_limit_reg == $past(req_in.data)) else $error("max limit write lost");

	// ----------------------------------------
	// speed and profile checks
	// ----------------------------------------
	vel_cap_a: assert property (1'b1 |=>
		$signed({demand_out.vel[31], demand_out.vel}) <= $signed({1'b0, $past(max_shaft_speed_reg)})
		&& $signed({demand_out.vel[31], demand_out.vel}) >= -$signed({1'b0, $past(max_shaft_speed_reg)}))
		else $error("velocity beyond shaft limit");
	cruise_cap_a: assert property ($past(profile_cruise_velocity_reg) > $past(max_shaft_speed_reg) |->
		demand_out.cruise == $past(max_shaft_speed_reg)) else $error("cruise not capped");
	pp_cruise_a: assert property (mode_in == MODE_PP && profile_cruise_velocity_reg <= max_shaft_speed_reg
		|=> demand_out.cruise == $past(profile_cruise_velocity_reg)) else $error("cruise not profile velocity");
	ramp_accel_a: assert property (ramp_mode |=> demand_out.accel == $past(profile_accel_rate_reg))
		else $error("accel not applied");
	ramp_decel_a: assert property (ramp_mode |=> demand_out.decel == $past(profile_decel_rate_reg))
		else $error("decel not applied");
	vel_setpt_a: assert property (vel_mode && velocity_setpoint_reg >= 0
		&& velocity_setpoint_reg <= $signed({1'b0, max_shaft_speed_reg})
		|=> demand_out.vel == $past(velocity_setpoint_reg))
		else $error("velocity setpoint not taken");
	vel_idle_a: assert property (!vel_mode && mode_in != MODE_PP |=> demand_out.vel == '0)
		else $error("velocity demand outside a velocity mode");
	pp_vel_a: assert property (mode_in == MODE_PP && !profile_cruise_velocity_reg[31] |=>
		demand_out.vel == demand_out.cruise) else $error("capped cruise not used as velocity");
	ramp_off_a: assert property (!ramp_mode |=> demand_out.accel == '0 && demand_out.decel == '0)
		else $error("ramp rates outside profile modes");
	speed_write_a: assert property (req_in.wr && hit(req_in, IDX_MAX_SPEED, SUB_ZERO)
		|=> max_shaft_speed_reg == $past(req_in.data)) else $error("max speed write lost");
	cruise_write_a: assert property (req_in.wr && hit(req_in, IDX_PROFILE_VEL, SUB_ZERO)
		|=> profile_cruise_velocity_reg == $past(req_in.data)) else $error("profile velocity write lost");
	accel_write_a: assert property (req_in.wr && hit(req_in, IDX_ACCEL, SUB_ZERO)
		|=> profile_accel_rate_reg == $past(req_in.data)) else $error("acceleration write lost");
	decel_write_a: assert property (req_in.wr && hit(req_in, IDX_DECEL, SUB_ZERO)
		|=> profile_decel_rate_reg == $past(req_in.data)) else $error("deceleration write lost");
	setpt_write_a: assert property (req_in.wr && hit(req_in, IDX_VEL_SETPT, SUB_ZERO)
		|=> velocity_setpoint_reg == $past(req_in.data)) else $error("velocity setpoint write lost");

	// ----------------------------------------
	// object access checks
	// ----------------------------------------
	mask_read_a: assert property (req_in.rd && !req_in.wr && hit(req_in, IDX_DRIVE_MODES, SUB_ZERO)
		|=> ack_out && rd_data_out == DRIVE_MODES_VAL) else $error("capability mask wrong");
	mask_ro_a: assert property (req_in.wr && hit(req_in, IDX_DRIVE_MODES, SUB_ZERO) |=> abort_out && !ack_out)
		else $error("write to capability mask accepted");
	// a refusal is an abort pulse that leaves every object untouched
	refuse_keep_a: assert property (abort_out |-> !ack_out && $stable(min_position_limit_reg)
		&& $stable(max_position_limit_reg) && $stable(max_shaft_speed_reg) && $stable(profile_cruise_velocity_reg)
		&& $stable(profile_accel_rate_reg) && $stable(profile_decel_rate_reg) && $stable(velocity_setpoint_reg))
		else $error("refused request changed an object");

	// ----------------------------------------
	// node id checks
	// ----------------------------------------
	// the floor applies only on a revert; otherwise the id holds
	node_floor_a: assert property (revert_in && node_id_in < NODE_ID_W'(NODE_ID_FLOOR)
		|=> node_id_out == NODE_ID_W'(NODE_ID_FLOOR)) else $error("node id not lifted");
	node_keep_a: assert property (revert_in && node_id_in >= NODE_ID_W'(NODE_ID_FLOOR)
		|=> node_id_out == $past(node_id_in)) else $error("valid node id altered");
	node_hold_a: assert property (!revert_in |=> node_id_out == $past(node_id_out))
		else $error("node id moved without a revert");

	// ----------------------------------------
	// coverage of the main scenarios
	// ----------------------------------------
	clip_low_c: cover property (target_valid_in && target_pos_in < min_position_limit_reg);
	cruise_cap_c: cover property (mode_in == MODE_PP && profile_cruise_velocity_reg > max_shaft_speed_reg);
	node_lift_c: cover property (revert_in && node_id_in < NODE_ID_W'(NODE_ID_FLOOR));
	write_read_c: cover property (req_in.wr ##2 req_in.rd ##1 ack_out);
	vel_neg_clamp_c: cover property (vel_mode && velocity_setpoint_reg < -$signed({1'b0, max_shaft_speed_reg}));

endmodule // motion_limit_object_bank

// ===== logic/motion_limit_pkg.sv
// constants and carrier types for the motion limit object bank
//
// Overview of operation
// - clip new target position into limits
// - cap shaft velocity both directions, default 1000
// - profile velocity above max speed uses max
// - profile position cruises at profile velocity
// - profile acceleration ramps up, PP and PV
// - profile deceleration ramps down, PP and PV
// - target velocity is velocity setpoint, PV and CSV
// - drive mode bitmask reads 647, read-only
// - native revert lifts node id below 10
// - cyclic position drives target within limits
package motion_limit_pkg;

	// ----------------------------------------
	// object indices and subindices
	// ----------------------------------------
	localparam logic [15:0] IDX_POS_LIMIT   = 16'h607d;
	localparam logic [15:0] IDX_MAX_SPEED   = 16'h6080;
	localparam logic [15:0] IDX_PROFILE_VEL = 16'h6081;
	localparam logic [15:0] IDX_ACCEL       = 16'h6083;
	localparam logic [15:0] IDX_DECEL       = 16'h6084;
	localparam logic [15:0] IDX_VEL_SETPT   = 16'h60ff;
	localparam logic [15:0] IDX_DRIVE_MODES = 16'h6502;
	localparam logic [7:0]  SUB_ZERO        = 8'h00;
	localparam logic [7:0]  SUB_MIN_POS     = 8'h01;
	localparam logic [7:0]  SUB_MAX_POS     = 8'h02;

	// ----------------------------------------
	// reset values and fixed contents
	// ----------------------------------------
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
	localparam logic [31:0] RST_MAX_SPEED   = 32'h0000_03e8;
	localparam logic [31:0] DRIVE_MODES_VAL = 32'h0000_0287;
	localparam logic [7:0]  NODE_ID_FLOOR   = 8'h0a;

	// ----------------------------------------
	// motion mode codes
	// ----------------------------------------
	localparam logic [7:0] MODE_PP  = 8'h01;
	localparam logic [7:0] MODE_PV  = 8'h03;
	localparam logic [7:0] MODE_CSP = 8'h08;
	localparam logic [7:0] MODE_CSV = 8'h09;

	// object access request from the protocol engine
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} obj_req_t;

	// limited setpoints handed to the motion loops
	typedef struct packed {
		logic signed [31:0] pos;
		logic signed [31:0] vel;
		logic [31:0]        cruise;
		logic [31:0]        accel;
		logic [31:0]        decel;
	} motion_set_t;

endpackage

// ===== verif/motion_limit_object_bank_tb.sv
// self-checking bench for the motion limit object bank
`timescale 1ns/1ps
module motion_limit_object_bank_tb;
	import motion_limit_pkg::*;
	logic ref_clk_in, resetn_in, target_valid_in, revert_in, ack_out, abort_out;
	logic signed [31:0] target_pos_in;
	logic [7:0]         mode_in, node_id_in, node_id_out;
	logic [31:0]        rd_data_out, q;
	logic [1:0]         rsp;
	obj_req_t           req_in;
	motion_set_t        demand_out;
	int num_errors = 0;
	int n_compared = 0;
	logic [15:0] it [7] = '{16'h607d, 16'h607d, 16'h6080, 16'h6081, 16'h6083, 16'h6084, 16'h60ff};
	logic [7:0]  st [7] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	motion_limit_object_bank #(.NODE_ID_W(8)) u_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.req_in(req_in), .rd_data_out(rd_data_out), .ack_out(ack_out), .abort_out(abort_out),
		.target_pos_in(target_pos_in), .target_valid_in(target_valid_in), .mode_in(mode_in),
		.node_id_in(node_id_in), .revert_in(revert_in), .node_id_out(node_id_out), .demand_out(demand_out));
	obj_master u_master (.ref_clk_in(ref_clk_in), .req_out(req_in), .rd_data_in(rd_data_out),
		.ack_in(ack_out), .abort_in(abort_out));

	// ----------------------------------------
	// clock, checks and bus helpers
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] exp, input logic [1:0] er);
		u_master.access(1'b0, i, s, 32'h0, q, rsp);
		chk({30'h0, rsp}, {30'h0, er});
		chk(q, exp); // an aborted read returns zero
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic [1:0] er);
		u_master.access(1'b1, i, s, d, q, rsp);
		chk({30'h0, rsp}, {30'h0, er});
	endtask
	// one target pulse, clipped result due one cycle later
	task automatic tgt(input logic [31:0] t, input logic [31:0] exp);
		@(posedge ref_clk_in);
		#1 target_valid_in = 1'b1;
		target_pos_in = t;
		@(posedge ref_clk_in);
		#1 target_valid_in = 1'b0;
		target_pos_in = ~t;
		chk(demand_out.pos, exp);
	endtask
	task automatic settle(input logic [7:0] m);
		@(posedge ref_clk_in);
		#1 mode_in = m;
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset;
		for (int i = 0; i < 7; i++) rd(it[i], st[i], (i == 2) ? 32'h0000_03e8 : 32'h0, 2'h1);
		rd(16'h6502, 8'h00, 32'h0000_0287, 2'h1);
		chk({24'h0, node_id_out}, 32'h0000_000a);
	endtask
	// write then read straight back, refusals change nothing
	task automatic test_access;
		for (int i = 0; i < 7; i++) begin
			wr(it[i], st[i], 32'ha5c3_0000 | i, 2'h1);
			rd(it[i], st[i], 32'ha5c3_0000 | i, 2'h1);
		end
		wr(16'h6502, 8'h00, 32'h0, 2'h2);
		rd(16'h6502, 8'h00, 32'h0000_0287, 2'h1);
		rd(16'h6085, 8'h00, 32'h0, 2'h2);
		wr(16'h607d, 8'h03, 32'h1, 2'h2);
		rd(16'h607d, 8'h01, 32'ha5c3_0000, 2'h1);
	endtask
	task automatic test_clip;
		wr(16'h607d, 8'h01, 32'hffff_ff9c, 2'h1);
		wr(16'h607d, 8'h02, 32'h0000_00c8, 2'h1);
		settle(8'h08);
		tgt(32'hffff_fe0c, 32'hffff_ff9c);
		tgt(32'h0000_0032, 32'h0000_0032);
		tgt(32'h0000_012c, 32'h0000_00c8);
		tgt(32'h0000_00c8, 32'h0000_00c8);
		tgt(32'hffff_ff9c, 32'hffff_ff9c);
	endtask
	task automatic test_speed;
		wr(16'h6080, 8'h00, 32'h0000_01f4, 2'h1);
		wr(16'h6081, 8'h00, 32'h0000_0320, 2'h1);
		wr(16'h6083, 8'h00, 32'h0000_0011, 2'h1);
		wr(16'h6084, 8'h00, 32'h0000_0022, 2'h1);
		wr(16'h60ff, 8'h00, 32'hffff_fc7c, 2'h1);
		settle(8'h01);
		chk(demand_out.cruise, 32'h0000_01f4);
		chk(demand_out.vel, 32'h0000_01f4);
		chk(demand_out.accel, 32'h0000_0011);
		chk(demand_out.decel, 32'h0000_0022);
		settle(8'h03);
		chk(demand_out.vel, 32'hffff_fe0c);
		chk(demand_out.decel, 32'h0000_0022);
		wr(16'h60ff, 8'h00, 32'h0000_012c, 2'h1);
		settle(8'h09);
		chk(demand_out.vel, 32'h0000_012c);
		chk(demand_out.accel, 32'h0);
	endtask
	task automatic test_revert;
		for (int i = 8; i < 12; i++) begin
			@(posedge ref_clk_in);
			#1 revert_in = 1'b1;
			node_id_in = i[7:0];
			@(posedge ref_clk_in);
			#1 revert_in = 1'b0;
			chk({24'h0, node_id_out}, (i < 10) ? 32'h0000_000a : i);
		end
	endtask

	// reset again mid-run: every object must return to its reset value
	task automatic test_mid_reset;
		@(posedge ref_clk_in);
		#1 resetn_in = 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1 resetn_in = 1'b1;
		test_reset();
	endtask

	task automatic print_verdict;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// watchdog: the whole sequence needs about 130 cycles
	initial begin
		#200000;
		num_errors++;
		print_verdict();
	end
	initial begin
		{resetn_in, target_valid_in, revert_in} = 3'h0;
		target_pos_in = 32'h0;
		mode_in = 8'h00;
		node_id_in = 8'h00;
		repeat (10) @(posedge ref_clk_in);
		#1 resetn_in = 1'b1;
		test_reset();
		test_access();
		test_clip();
		test_speed();
		test_revert();
		test_mid_reset();
		print_verdict();
	end
endmodule // motion_limit_object_bank_tb

// ===== verif/obj_master.sv
// behavioural object dictionary master driving the object request port
`timescale 1ns/1ps
module obj_master
	import motion_limit_pkg::*;
(
	input  wire logic        ref_clk_in,
	output obj_req_t         req_out,
	input  wire logic [31:0] rd_data_in,
	input  wire logic        ack_in,
	input  wire logic        abort_in
);
	initial req_out = '0;
	// one request per call, a lone master on the line
	task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] resp);
		@(posedge ref_clk_in);
		#1 req_out = '{wr, ~wr, idx, sub, d};
		@(posedge ref_clk_in);
		// released lines drop wr and rd and show inverted index, subindex and data, never the stale ones
		#1 req_out = '{1'b0, 1'b0, ~idx, ~sub, ~d};
		q = rd_data_in;
		resp = {abort_in, ack_in};
	endtask
endmodule // obj_master
